/* File: src/wake_host.sv */
// Two-wire bus master that reads and programs the wake timer
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "wake_map.svh"
// Functional notes
// - Compare value moves as three whole bytes, most significant first.
// - Compare read returns the time value while the device reset pin is low.
// - SDA changes only while SCL is low; otherwise start or stop.
// - Master releases SDA after eighth clock; device acknowledges on ninth.
// - First byte carries address 0110010 and a direction bit.
// - Bytes shift bit 7 first; device acknowledges written bytes low.
// - Master acknowledges read bytes except the last, then stops.
// - Start without stop plus address again is a repeated start.
// - Write pointer byte has bit 7 set and bit 0 set.
// - Bytes three to five load the compare value; send exactly three.
// - Compare read: dummy write pointer bit 7 clear, bit 0 set, restart.
// - Stop clears the pointer; no stop between dummy write and read.
// - Recovery is start, nine released clocks, then stop.
module wake_host import wake_pkg::*; #(
  parameter int QUARTER_CYC = `QUARTER_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic dev_rst_n,
  input wire logic dev_int
);
  cmd_t cmd;
  stat_t stat;
  state_t st_q;
  op_t op_q;
  uop_t uop;
  logic tick;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [3:0] step_q;
  logic [7:0] sh_q;
  logic [23:0] rd_q;
  logic [23:0] wv_q;
  logic nack_q, done_q, drive_bit;
  logic sda_meta_q, sda_s_q, int_meta_q, int_s_q;

  if (QUARTER_CYC < 2) begin : g_bad_quarter
    $error("QUARTER_CYC too small for the bit sequencer");
  end

  axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .cmd(cmd),
    .stat(stat)
  );

  scl_tick #(.QUARTER_CYC(QUARTER_CYC)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  // Program of bus steps for each operation
  function automatic uop_t prog(input op_t op, input logic [3:0] step, input logic [23:0] wv);
    uop_t u;
    u = '{kind: K_STOP, data: `FILL_BYTE, last: 1'b0};
    unique case (op)
      OP_READ_TIME: begin
        case (step)
          4'h0: u.kind = K_START;
          4'h1: u = '{kind: K_WR, data: {`DEV_ADDR, 1'b1}, last: 1'b0};
          4'h2, 4'h3, 4'h4: u = '{kind: K_RD, data: `FILL_BYTE, last: step == 4'h4};
          default: ;
        endcase
      end
      OP_WRITE_CMP: begin
        case (step)
          4'h0: u.kind = K_START;
          4'h1: u = '{kind: K_WR, data: {`DEV_ADDR, 1'b0}, last: 1'b0};
          4'h2: u = '{kind: K_WR, data: `PTR_WRITE, last: 1'b0};
          4'h3: u = '{kind: K_WR, data: wv[23:16], last: 1'b0};
          4'h4: u = '{kind: K_WR, data: wv[15:8], last: 1'b0};
          4'h5: u = '{kind: K_WR, data: wv[7:0], last: 1'b1};
          default: ;
        endcase
      end
      OP_READ_CMP: begin
        case (step)
          4'h0, 4'h3: u.kind = K_START;
          4'h1: u = '{kind: K_WR, data: {`DEV_ADDR, 1'b0}, last: 1'b0};
          4'h2: u = '{kind: K_WR, data: `PTR_READ, last: 1'b0};
          4'h4: u = '{kind: K_WR, data: {`DEV_ADDR, 1'b1}, last: 1'b0};
          4'h5, 4'h6, 4'h7: u = '{kind: K_RD, data: `FILL_BYTE, last: step == 4'h7};
          default: ;
        endcase
      end
      OP_RECOVER: begin
        case (step)
          4'h0: u.kind = K_START;
          4'h1: u = '{kind: K_RD, data: `FILL_BYTE, last: 1'b1};
          default: ;
        endcase
      end
    endcase
    return u;
  endfunction

  assign uop = prog(op_q, step_q, wv_q);

  // Pins are asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_meta_q <= 1'b1;
      sda_s_q <= 1'b1;
      int_meta_q <= 1'b0;
      int_s_q <= 1'b0;
    end else begin
      sda_meta_q <= sda_i;
      sda_s_q <= sda_meta_q;
      int_meta_q <= dev_int;
      int_s_q <= int_meta_q;
    end
  end

  // Sequencer: each bus step spends four quarter periods per bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE;
      op_q <= OP_READ_TIME;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      step_q <= 4'h0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          if (cmd.go) begin
            op_q <= cmd.op;
            step_q <= 4'h0;
            st_q <= S_LOAD;
          end
        end
        S_LOAD: begin
          ph_q <= 2'h0;
          bit_q <= 4'h0;
          unique case (uop.kind)
            K_START: st_q <= S_START;
            K_STOP: st_q <= S_STOP;
            K_WR, K_RD: st_q <= S_BIT;
          endcase
        end
        S_START: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h3) begin
              step_q <= step_q + 4'h1;
              st_q <= S_LOAD;
            end
          end
        end
        S_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h3) begin
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                // Refused byte: stop at once so no more data goes out
                if (nack_q) begin
                  st_q <= S_STOP;
                end else begin
                  step_q <= step_q + 4'h1;
                  st_q <= S_LOAD;
                end
              end
            end
          end
        end
        S_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h3) begin
              st_q <= S_IDLE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  always_comb begin
    if (uop.kind == K_WR) begin
      drive_bit = (bit_q == 4'h8) ? 1'b0 : !sh_q[7];
    end else begin
      drive_bit = (bit_q == 4'h8) ? !uop.last : 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (tick) begin
      unique case (st_q)
        S_START: begin
          unique case (ph_q)
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            2'h3: scl_oe <= 1'b1;
          endcase
        end
        S_BIT: begin
          unique case (ph_q)
            2'h0: sda_oe <= drive_bit;
            2'h1: scl_oe <= 1'b0;
            2'h2: ;
            2'h3: scl_oe <= 1'b1;
          endcase
        end
        S_STOP: begin
          unique case (ph_q)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            2'h3: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  // Open drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign dev_rst_n = cmd.rst_pin;

  // Shifting, captured read bytes and completion flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_q <= 8'h00;
      rd_q <= 24'h00_0000;
      wv_q <= 24'h00_0000;
      nack_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (st_q == S_IDLE && cmd.go) begin
        wv_q <= cmd.wval;
        nack_q <= 1'b0;
        done_q <= 1'b0;
      end
      if (st_q == S_LOAD) begin
        sh_q <= uop.data;
      end
      if (st_q == S_BIT && tick && ph_q == 2'h2) begin
        if (bit_q != 4'h8) begin
          sh_q <= {sh_q[6:0], sda_s_q};
        end else if (uop.kind == K_WR) begin
          nack_q <= sda_s_q;
        end else if (op_q != OP_RECOVER) begin
          rd_q <= {rd_q[15:0], sh_q};
        end
      end
      if (st_q == S_STOP && tick && ph_q == 2'h3) begin
        done_q <= 1'b1;
      end
    end
  end

  assign stat.busy = st_q != S_IDLE;
  assign stat.done = done_q;
  assign stat.nack = nack_q;
  assign stat.int_level = int_s_q;
  assign stat.rval = rd_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  scl_quiet_a: assert property (
    st_q == S_BIT && $past(st_q) == S_BIT && !scl_oe && !$past(scl_oe) |-> $stable(sda_oe))
    else $error("sda moved while scl high");

  ack_release_a: assert property (
    st_q == S_BIT && uop.kind == K_WR && bit_q == 4'h8 && ph_q == 2'h2 |-> !sda_oe && !scl_oe)
    else $error("sda not released for acknowledge");

  addr_byte_a: assert property (
    st_q == S_LOAD && uop.kind == K_WR && (step_q == 4'h1 || $past(uop.kind) == K_START)
    |-> uop.data[7:1] == `DEV_ADDR)
    else $error("wrong target address");

  msb_first_a: assert property (
    st_q == S_BIT && uop.kind == K_WR && bit_q < 4'h8 && ph_q == 2'h2
    |-> sda_oe == !uop.data[3'h7 - bit_q[2:0]])
    else $error("data bit out of order");

  last_nack_a: assert property (
    st_q == S_BIT && uop.kind == K_RD && bit_q == 4'h8 && ph_q == 2'h2 |-> sda_oe == !uop.last)
    else $error("read acknowledge wrong");

  ptr_write_a: assert property (
    st_q == S_LOAD && op_q == OP_WRITE_CMP && step_q == 4'h2 |-> uop.data == `PTR_WRITE)
    else $error("write pointer byte wrong");

  three_bytes_a: assert property (
    st_q == S_LOAD && op_q == OP_WRITE_CMP && uop.kind == K_STOP |-> step_q == 4'h6)
    else $error("compare write not three bytes");

  ptr_read_a: assert property (
    st_q == S_LOAD && op_q == OP_READ_CMP && step_q == 4'h2
    |-> uop.data == `PTR_READ ##1 st_q == S_BIT)
    else $error("read pointer byte wrong");

  no_stop_a: assert property (
    st_q == S_LOAD && op_q == OP_READ_CMP && step_q == 4'h3 |-> uop.kind == K_START)
    else $error("stop between dummy write and read");

  recover_rel_a: assert property (
    st_q == S_BIT && op_q == OP_RECOVER && (ph_q != 2'h0 || bit_q != 4'h0) |-> !sda_oe)
    else $error("sda driven during recovery");

  stop_done_a: assert property (
    st_q == S_STOP && tick && ph_q == 2'h3 |=> st_q == S_IDLE && done_q && !sda_oe && !scl_oe)
    else $error("stop did not release bus");

  time_read_c: cover property (st_q == S_STOP && tick && ph_q == 2'h3 && op_q == OP_READ_TIME);
  cmp_write_c: cover property (st_q == S_STOP && tick && ph_q == 2'h3 && op_q == OP_WRITE_CMP);
  cmp_read_c: cover property (st_q == S_STOP && tick && ph_q == 2'h3 && op_q == OP_READ_CMP);
  refused_c: cover property (st_q == S_STOP && nack_q);
endmodule

/* File: src/wake_map.svh */
// Register offsets, field positions, reset values and bus timing for the wake timer host
`ifndef WAKE_MAP_SVH
`define WAKE_MAP_SVH

`define OFF_CTRL 32'h0000_0000
`define OFF_STATUS 32'h0000_0004
`define OFF_WVAL 32'h0000_0008
`define OFF_RVAL 32'h0000_000c

`define CTRL_OP_LSB 0
`define CTRL_RSTPIN_BIT 4
`define CTRL_GO_BIT 8
`define CTRL_RESET 32'h0000_0010

`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_NACK_BIT 2
`define STAT_INT_BIT 3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define DEV_ADDR 7'h32
`define PTR_WRITE 8'h81
`define PTR_READ 8'h01
`define FILL_BYTE 8'hff

`define CLK_PERIOD_NS 5
`define SCL_PERIOD_NS 3000
`define QUARTER_CYC (((`SCL_PERIOD_NS) + 4 * (`CLK_PERIOD_NS) - 1) / (4 * (`CLK_PERIOD_NS)))

`endif

/* File: src/wake_pkg.sv */
// Types shared by the wake timer host modules
package wake_pkg;

  typedef enum logic [1:0] {
    OP_READ_TIME = 2'h0,
    OP_WRITE_CMP = 2'h1,
    OP_READ_CMP = 2'h2,
    OP_RECOVER = 2'h3
  } op_t;

  typedef enum logic [1:0] {
    K_START = 2'h0,
    K_WR = 2'h1,
    K_RD = 2'h2,
    K_STOP = 2'h3
  } kind_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_LOAD = 5'h02,
    S_START = 5'h04,
    S_BIT = 5'h08,
    S_STOP = 5'h10
  } state_t;

  typedef struct packed {
    kind_t kind;
    logic [7:0] data;
    logic last;
  } uop_t;

  typedef struct packed {
    op_t op;
    logic go;
    logic rst_pin;
    logic [23:0] wval;
  } cmd_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic nack;
    logic int_level;
    logic [23:0] rval;
  } stat_t;

endpackage

/* File: src/scl_tick.sv */
// Quarter bit period enable for the serial clock sequencer
`timescale 1ns/1ps
`include "wake_map.svh"
module scl_tick #(
  parameter int QUARTER_CYC = `QUARTER_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  logic [15:0] cnt_q;

  if (QUARTER_CYC < 2 || QUARTER_CYC > 65535) begin : g_bad_quarter
    $error("QUARTER_CYC out of range");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q == 16'(QUARTER_CYC - 1)) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign tick = (cnt_q == 16'(QUARTER_CYC - 1));
endmodule

/* File: src/axil_regs.sv */
// AXI4-Lite register file holding commands and status of the wake timer host
`timescale 1ns/1ps
`include "wake_map.svh"
module axil_regs import wake_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output cmd_t cmd,
  input stat_t stat
);
  logic aw_got_q, w_got_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic wr_do, wr_hit;
  logic [31:0] ctrl_rd, stat_rd;

  assign awready = !aw_got_q && !bvalid;
  assign wready = !w_got_q && !bvalid;
  assign arready = !rvalid;
  assign wr_do = aw_got_q && w_got_q;
  assign wr_hit = awaddr_q == `OFF_CTRL || awaddr_q == `OFF_WVAL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_do) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Go is dropped while busy; software polls busy first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd.op <= op_t'(2'(`CTRL_RESET >> `CTRL_OP_LSB));
      cmd.rst_pin <= 1'(`CTRL_RESET >> `CTRL_RSTPIN_BIT);
      cmd.go <= 1'b0;
      cmd.wval <= 24'h00_0000;
    end else begin
      cmd.go <= wr_do && awaddr_q == `OFF_CTRL && wstrb_q[1] && wdata_q[`CTRL_GO_BIT]
        && !stat.busy;
      if (wr_do && awaddr_q == `OFF_CTRL && wstrb_q[0]) begin
        cmd.op <= op_t'(wdata_q[`CTRL_OP_LSB +: 2]);
        cmd.rst_pin <= wdata_q[`CTRL_RSTPIN_BIT];
      end
      for (int i = 0; i < 3; i++) begin
        if (wr_do && awaddr_q == `OFF_WVAL && wstrb_q[i]) begin
          cmd.wval[8*i +: 8] <= wdata_q[8*i +: 8];
        end
      end
    end
  end

  assign ctrl_rd = {27'h0, cmd.rst_pin, 2'h0, cmd.op};
  assign stat_rd = {28'h0, stat.int_level, stat.nack, stat.done, stat.busy};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      unique case (araddr)
        `OFF_CTRL: rdata <= ctrl_rd;
        `OFF_STATUS: rdata <= stat_rd;
        `OFF_WVAL: rdata <= {8'h00, cmd.wval};
        `OFF_RVAL: rdata <= {8'h00, stat.rval};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

/* File: testbench/wake_dev_model.sv */
// Behavioural wake timer device seen on the two-wire bus
`timescale 1ns/1ps
module wake_dev_model #(
  parameter logic [23:0] TIME0 = 24'h3a5c17
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic rst_n,
  output logic pull,
  output logic int_o
);
  logic [23:0] cmp_q = 24'h000000;
  logic [23:0] tim_q = TIME0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'hff;
  logic act = 1'b0;
  logic rdp = 1'b0;
  logic dir = 1'b0;
  logic ptr = 1'b1;
  logic mnack = 1'b0;
  int bitn = 0;
  int nb = 0;
  int ri = 0;
  initial pull = 1'b0;
  // match raises interrupt; timer frozen, no debounce
  assign int_o = rst_n && (tim_q == cmp_q);
  always @(negedge sda) begin
    if (scl) begin
      act = 1'b1;
      rdp = 1'b0;
      bitn = -1;
      nb = 0;
    end
  end
  // stop resets port; a held low blocks it
  always @(posedge sda) begin
    if (scl) begin
      act = 1'b0;
      ptr = 1'b1;
    end
  end
  // sample msb first, then master acknowledge
  always @(posedge scl) begin
    if (act && bitn < 8) sh = {sh[6:0], sda};
    if (act && bitn == 8) mnack = sda;
  end
  // ack through ninth clock; only pulls low
  always @(negedge scl) begin
    if (act) begin
      bitn = bitn + 1;
      if (bitn > 0 && bitn < 8 && rdp) pull = !tx[7 - bitn];
      if (bitn == 8) begin
        pull = 1'b0;
        if (!rdp) byte_in();
      end
      if (bitn == 9) begin
        bitn = 0;
        pull = 1'b0;
        if (rdp && mnack) act = 1'b0;
        else if (dir) send_next();
      end
    end
  end
  task automatic byte_in();
    if (nb == 0) begin
      dir = sh[0];
      ri = 0;
      if (sh[7:1] != 7'h32) act = 1'b0;
      else pull = 1'b1;
    end else begin
      // value bytes refused while reset pin low; pointer byte always taken
      pull = (nb == 1) || rst_n;
      if (nb == 1) ptr = sh[7];
      if (nb > 1 && nb < 5 && rst_n) cmp_q[39 - 8 * nb -: 8] = sh;
      if (nb == 4 && rst_n) tim_q = 24'h000000;
    end
    nb = nb + 1;
  endtask
  // source, msb byte first, ones after three
  task automatic send_next();
    logic [23:0] v;
    v = (!ptr && rst_n) ? cmp_q : tim_q;
    rdp = 1'b1;
    tx = (ri < 3) ? v[23 - 8 * ri -: 8] : 8'hff;
    ri = ri + 1;
    pull = !tx[7];
  endtask
endmodule

/* File: testbench/test_wake_host.sv */
// Self-checking bench for the wake timer host
`timescale 1ns/1ps
`include "wake_map.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module test_wake_host import wake_pkg::*;;
  localparam logic [23:0] T0 = 24'h3a5c17;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, seed = 32'hb4d3;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe;
  logic dev_rst_n, dev_int, pull;
  logic [1:0] bresp, rresp;
  logic [23:0] cmp = 24'h0, tim = T0, wv_exp = 24'h0;
  wire scl, sda;
  int n_fail = 0, cmp_count = 0, n_st = 0, n_sp = 0;
  always #2.5 aclk = ~aclk;
  // Open drain wires with pull-ups
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_oe || pull) ? sda_o : 1'b1;
  wake_host #(.QUARTER_CYC(3)) uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe,
    .dev_rst_n, .dev_int);
  wake_dev_model #(.TIME0(T0)) dev (.scl, .sda, .rst_n(dev_rst_n), .pull, .int_o(dev_int));
  // starts and stops seen on the wire
  always @(negedge sda) if (scl === 1'b1) n_st++;
  always @(posedge sda) if (scl === 1'b1) n_sp++;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [31:0] ctrl_word(input op_t op, input logic rst);
    logic [31:0] w;
    w = 32'h0;
    w[`CTRL_OP_LSB +: 2] = op;
    w[`CTRL_RSTPIN_BIT] = rst;
    w[`CTRL_GO_BIT] = 1'b1;
    return w;
  endfunction
  function automatic logic [23:0] exp_rd(input op_t op, input logic rst);
    return (op == OP_READ_CMP && rst) ? cmp : tim;
  endfunction
  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    $display("BAD t=%0t wait limit reached", $time);
    tally_and_finish();
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 100 && !hb; k++) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
    if (!hb) hang();
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    hr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 100 && !hr; k++) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
    if (!hr) hang();
  endtask
  // One link operation, waited for, with wire framing and status checked
  task automatic run_op(input op_t op, input logic rst, input logic en, output logic [23:0] rv);
    logic [1:0] r;
    logic [31:0] st, d;
    int s0, p0, k;
    s0 = n_st;
    p0 = n_sp;
    st = 32'h0;
    axw(`OFF_CTRL, ctrl_word(op, rst), r);
    `CHK(dev_rst_n, rst)
    for (k = 0; k < 3000 && !(st[`STAT_DONE_BIT] && !st[`STAT_BUSY_BIT]); k++) begin
      axr(`OFF_STATUS, st, r);
    end
    if (!(st[`STAT_DONE_BIT] && !st[`STAT_BUSY_BIT])) hang();
    `CHK(st[`STAT_NACK_BIT], en)
    if (op == OP_WRITE_CMP && rst) begin
      tim = 24'h0;
      cmp = wv_exp;
    end
    `CHK(st[`STAT_INT_BIT], rst && (tim == cmp))
    `CHK(n_st - s0, (op == OP_READ_CMP) ? 2 : 1)
    `CHK(n_sp - p0, 1)
    axr(`OFF_RVAL, d, r);
    rv = d[23:0];
  endtask
  initial begin
    logic [31:0] d;
    logic [23:0] rv, v;
    logic [1:0] r;
    op_t op;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`OFF_CTRL, d, r);
    `CHK(d, `CTRL_RESET)
    axw(32'h0000_0010, 32'h1, r);
    `CHK(r, `RESP_SLVERR)
    axr(32'h0000_0010, d, r);
    `CHK(r, `RESP_SLVERR)
    axw(`OFF_STATUS, 32'h1, r);
    `CHK(r, `RESP_SLVERR)
    $display("register map test done");
    for (int i = 0; i < 4; i++) begin
      op = op_t'({i[1], 1'b0});
      run_op(op, i[0], 1'b0, rv);
      `CHK(rv, exp_rd(op, i[0]))
    end
    $display("read source test done");
    // Write refused while the device reset pin is low
    wv_exp = 24'ha5a5a5;
    axw(`OFF_WVAL, {8'h00, wv_exp}, r);
    run_op(OP_WRITE_CMP, 1'b0, 1'b1, rv);
    run_op(OP_READ_CMP, 1'b1, 1'b0, rv);
    `CHK(rv, cmp)
    $display("refused write test done");
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 24'h000000 : (i == 1) ? 24'hffffff : seed[23:0];
      wv_exp = v;
      axw(`OFF_WVAL, {8'h00, v}, r);
      run_op(OP_WRITE_CMP, 1'b1, 1'b0, rv);
      run_op(OP_READ_CMP, 1'b1, 1'b0, rv);
      `CHK(rv, v)
      run_op(OP_READ_TIME, 1'b1, 1'b0, rv);
      `CHK(rv, 24'h000000)
    end
    $display("compare write test done");
    run_op(OP_RECOVER, 1'b1, 1'b0, rv);
    run_op(OP_READ_TIME, 1'b1, 1'b0, rv);
    `CHK(rv, tim)
    $display("recovery test done");
    tally_and_finish();
  end
endmodule
